// ===== core/key_port_consts.vh
// Register offsets, field positions and reset values of the key matrix port block.
`ifndef KEY_PORT_CONSTS_VH
`define KEY_PORT_CONSTS_VH
// ===========================================================================
// Register offsets (word index on the plain register port)
`define KP_ADDR_W        4
`define KP_DATA_W        16
`define KP_REG_CTRL      4'h0
`define KP_REG_TRI_DIR   4'h1
`define KP_REG_TRI_OUT   4'h2
`define KP_REG_TRI_RES   4'h3
`define KP_REG_TRI_LVL   4'h4
`define KP_REG_BDIR_DIR  4'h5
`define KP_REG_BDIR_OUT  4'h6
`define KP_REG_GDIR_OUT  4'h7
`define KP_REG_CARRIER   4'h8
`define KP_REG_PIN_IN    4'h9
`define KP_REG_IRQ_STAT  4'hA
`define KP_REG_IRQ_MASK  4'hB
`define KP_REG_STANDBY   4'hC
// ===========================================================================
// Control register fields
`define KP_CTRL_KEYMAT   0
`define KP_CTRL_GDIR_OUT 1
// ===========================================================================
// Status and mask fields
`define KP_EV_TRI        0
`define KP_EV_KEY        1
`define KP_EV_BDIR       2
`define KP_EV_GDIR       3
`define KP_EV_W          4
// ===========================================================================
// Reset values
`define KP_RST_KEYMAT    1'b0
`define KP_RST_GDIR_OUT  1'b1
`define KP_RST_TRI3      3'h0
`define KP_RST_NIB       4'h0
`define KP_RST_CARRIER   1'b0
`endif

// ===== core/key_port.v
// Key matrix port block: four port groups, standby wake logic, register port and interrupt.
// Function
// - Three-bit port, direction chosen per bit.
// - Key-matrix input use: per bit wake level and resistor attach selectable.
// - Resistor on, low wake: pull-up, low input releases standby.
// - Resistor on, high wake: pull-down, high input releases standby.
// - Resistor off: no pull, selected wake level still releases standby.
// - Three-bit output in key-matrix use is open-drain, low only.
// - Three-bit output without key-matrix use is push-pull.
// - Without key-matrix use, input resistor attach and direction per bit.
// - Four-bit input-only key port with pull-ups on all bits.
// - Any low bit of input-only key port releases standby.
// - Second four-bit port, per bit direction, pull-ups on input bits.
// - Any low input bit of second port releases standby.
// - Output bits of second port are open-drain, low only.
// - Third four-bit port, direction switched for all bits together.
// - Group port as input: pull-ups, any low bit releases standby.
// - Group port bits are key strobes, with pull-ups on every bit when input.
// - Carrier output active-high, low after reset.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`include "key_port_consts.vh"
module key_port
(
  // Clock and reset
  input  wire                     i_clk,
  input  wire                     i_rst_n,
  // Register port
  input  wire [`KP_ADDR_W-1:0]    i_addr,
  input  wire [`KP_DATA_W-1:0]    i_wdata,
  input  wire                     i_wr,
  input  wire                     i_rd,
  output reg  [`KP_DATA_W-1:0]    o_rdata,
  // Three-bit port
  input  wire [2:0]               i_tri_port,
  output reg  [2:0]               o_tri_port,
  output reg  [2:0]               o_tri_port_oe,
  output reg  [2:0]               o_tri_pull_up,
  output reg  [2:0]               o_tri_pull_dn,
  // Input-only key port
  input  wire [3:0]               i_key_in_port,
  output reg  [3:0]               o_key_in_pull_up,
  // Per-bit direction port
  input  wire [3:0]               i_bit_dir_port,
  output reg  [3:0]               o_bit_dir_port,
  output reg  [3:0]               o_bit_dir_port_oe,
  output reg  [3:0]               o_bit_dir_pull_up,
  // Group direction port
  input  wire [3:0]               i_group_dir_port,
  output reg  [3:0]               o_group_dir_port,
  output reg  [3:0]               o_group_dir_port_oe,
  output reg  [3:0]               o_group_dir_pull_up,
  // Carrier, standby and interrupt
  output reg                      o_ir_carrier_out,
  output reg                      o_standby,
  output reg                      o_irq
);

  // =========================================================================
  // Helpers
  // A bit wakes the part when it is an input and sits at its wake level.
  function [3:0] low_wake;
    input [3:0] pins;
    input [3:0] is_in;
    begin
      low_wake = ~pins & is_in;
    end
  endfunction

  // A strobe hits a register when it is high and the index matches.
  function reg_hit;
    input                  strobe;
    input [`KP_ADDR_W-1:0] addr;
    input [`KP_ADDR_W-1:0] idx;
    begin
      reg_hit = strobe && (addr == idx);
    end
  endfunction

  // =========================================================================
  // Pin synchronisers
  // Pins are asynchronous to i_clk; only the second stage is ever read.
  reg  [14:0] pin_meta_r;
  reg  [14:0] pin_sync_r;
  wire [2:0]  tri_in  = pin_sync_r[2:0];
  wire [3:0]  key_in  = pin_sync_r[6:3];
  wire [3:0]  bdir_in = pin_sync_r[10:7];
  wire [3:0]  gdir_in = pin_sync_r[14:11];

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_meta_r <= 15'h7FFF;
      pin_sync_r <= 15'h7FFF;
    end
    else
    begin
      pin_meta_r <= {i_group_dir_port, i_bit_dir_port, i_key_in_port, i_tri_port};
      pin_sync_r <= pin_meta_r;
    end
  end

  // =========================================================================
  // Control registers
  reg                   keymat_r;
  reg                   gdir_out_r;
  reg  [2:0]            tri_dir_r;
  reg  [2:0]            tri_out_r;
  reg  [2:0]            tri_res_r;
  reg  [2:0]            tri_lvl_r;
  reg  [3:0]            bdir_dir_r;
  reg  [3:0]            bdir_out_r;
  reg  [3:0]            gdir_dat_r;
  reg                   carrier_r;
  reg  [`KP_EV_W-1:0]   irq_mask_r;
  reg  [`KP_EV_W-1:0]   irq_stat_r;
  reg  [`KP_EV_W-1:0]   irq_stat_nxt;
  reg                   standby_r;
  reg                   standby_nxt;

  wire standby_req = reg_hit(i_wr, i_addr, `KP_REG_STANDBY) && i_wdata[0];
  wire stat_clear  = reg_hit(i_rd, i_addr, `KP_REG_IRQ_STAT);

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      keymat_r   <= `KP_RST_KEYMAT;
      gdir_out_r <= `KP_RST_GDIR_OUT;
      tri_dir_r  <= `KP_RST_TRI3;
      tri_out_r  <= `KP_RST_TRI3;
      tri_res_r  <= `KP_RST_TRI3;
      tri_lvl_r  <= `KP_RST_TRI3;
      bdir_dir_r <= `KP_RST_NIB;
      bdir_out_r <= `KP_RST_NIB;
      gdir_dat_r <= `KP_RST_NIB;
      carrier_r  <= `KP_RST_CARRIER;
      irq_mask_r <= {`KP_EV_W{1'b0}};
    end
    else if (i_wr)
    begin
      case (i_addr)
        `KP_REG_CTRL:
        begin
          keymat_r   <= i_wdata[`KP_CTRL_KEYMAT];
          gdir_out_r <= i_wdata[`KP_CTRL_GDIR_OUT];
        end
        `KP_REG_TRI_DIR:  tri_dir_r  <= i_wdata[2:0];
        `KP_REG_TRI_OUT:  tri_out_r  <= i_wdata[2:0];
        `KP_REG_TRI_RES:  tri_res_r  <= i_wdata[2:0];
        `KP_REG_TRI_LVL:  tri_lvl_r  <= i_wdata[2:0];
        `KP_REG_BDIR_DIR: bdir_dir_r <= i_wdata[3:0];
        `KP_REG_BDIR_OUT: bdir_out_r <= i_wdata[3:0];
        `KP_REG_GDIR_OUT: gdir_dat_r <= i_wdata[3:0];
        `KP_REG_CARRIER:  carrier_r  <= i_wdata[0];
        `KP_REG_IRQ_MASK: irq_mask_r <= i_wdata[`KP_EV_W-1:0];
        default:          carrier_r  <= carrier_r;
      endcase
    end
  end

  // =========================================================================
  // Wake detection
  // Three-bit port wakes only in key-matrix input use, at its chosen level.
  wire [2:0] tri_is_in  = ~tri_dir_r & {3{keymat_r}};
  wire [2:0] tri_wake   = tri_is_in & ~(tri_in ^ tri_lvl_r);
  wire       key_wake   = |low_wake(key_in, 4'hF);
  wire       bdir_wake  = |low_wake(bdir_in, ~bdir_dir_r);
  wire       gdir_wake  = |low_wake(gdir_in, {4{~gdir_out_r}});
  wire [`KP_EV_W-1:0] wake_ev = {gdir_wake, bdir_wake, key_wake, |tri_wake};
  wire       any_wake   = |wake_ev;

  // =========================================================================
  // Standby and interrupt status
  // A wake level that is already present when standby is requested releases it
  // one cycle later, so a held key never leaves the part asleep.
  always @*
  begin
    standby_nxt = standby_r;
    if (standby_req)
    begin
      standby_nxt = 1'b1;
    end
    if (standby_r && any_wake)
    begin
      standby_nxt = 1'b0;
    end
  end

  always @*
  begin
    irq_stat_nxt = irq_stat_r;
    if (stat_clear)
    begin
      irq_stat_nxt = {`KP_EV_W{1'b0}};
    end
    if (standby_r)
    begin
      // A release that lands on the clearing read is kept.
      irq_stat_nxt = irq_stat_nxt | wake_ev;
    end
  end

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      standby_r  <= 1'b0;
      irq_stat_r <= {`KP_EV_W{1'b0}};
    end
    else
    begin
      standby_r  <= standby_nxt;
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // =========================================================================
  // Pin drive and pull resistors
  reg [2:0] tri_o_nxt;
  reg [2:0] tri_oe_nxt;
  reg [2:0] tri_pu_nxt;
  reg [2:0] tri_pd_nxt;

  always @*
  begin
    if (keymat_r)
    begin
      tri_o_nxt  = 3'h0;
      tri_oe_nxt = tri_dir_r & ~tri_out_r;
    end
    else
    begin
      tri_o_nxt  = tri_out_r & tri_dir_r;
      tri_oe_nxt = tri_dir_r;
    end
    // The level bit picks the pull in both modes: low wake means pull-up.
    tri_pu_nxt = ~tri_dir_r & tri_res_r & ~tri_lvl_r;
    tri_pd_nxt = ~tri_dir_r & tri_res_r & tri_lvl_r;
  end

  // =========================================================================
  // Three-bit port pins
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tri_port    <= 3'h0;
      o_tri_port_oe <= 3'h0;
      o_tri_pull_up <= 3'h0;
      o_tri_pull_dn <= 3'h0;
    end
    else
    begin
      o_tri_port    <= tri_o_nxt;
      o_tri_port_oe <= tri_oe_nxt;
      o_tri_pull_up <= tri_pu_nxt;
      o_tri_pull_dn <= tri_pd_nxt;
    end
  end

  // =========================================================================
  // Input-only key port pulls
  // The pull-ups never switch off, so an idle return line cannot wake the part.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_key_in_pull_up <= 4'hF;
    end
    else
    begin
      o_key_in_pull_up <= 4'hF;
    end
  end

  // =========================================================================
  // Per-bit direction port pins
  // Output bits only ever sink, so a pressed key cannot short two drivers.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bit_dir_port    <= 4'h0;
      o_bit_dir_port_oe <= 4'h0;
      o_bit_dir_pull_up <= 4'hF;
    end
    else
    begin
      o_bit_dir_port    <= 4'h0;
      o_bit_dir_port_oe <= bdir_dir_r & ~bdir_out_r;
      o_bit_dir_pull_up <= ~bdir_dir_r;
    end
  end

  // =========================================================================
  // Group direction port pins
  // The group leaves reset driving low, so every strobe line starts active.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_group_dir_port    <= 4'h0;
      o_group_dir_port_oe <= 4'hF;
      o_group_dir_pull_up <= 4'h0;
    end
    else
    begin
      o_group_dir_port    <= 4'h0;
      o_group_dir_port_oe <= {4{gdir_out_r}} & ~gdir_dat_r;
      o_group_dir_pull_up <= {4{~gdir_out_r}};
    end
  end

  // =========================================================================
  // Carrier, standby and interrupt outputs
  // Standby and interrupt follow next-state values so they move with the status bits.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ir_carrier_out <= 1'b0;
      o_standby        <= 1'b0;
      o_irq            <= 1'b0;
    end
    else
    begin
      o_ir_carrier_out <= carrier_r;
      o_standby        <= standby_nxt;
      o_irq            <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // =========================================================================
  // Register read
  reg [`KP_DATA_W-1:0] rdata_nxt;

  always @*
  begin
    rdata_nxt = {`KP_DATA_W{1'b0}};
    case (i_addr)
      `KP_REG_CTRL:     rdata_nxt[1:0] = {gdir_out_r, keymat_r};
      `KP_REG_TRI_DIR:  rdata_nxt[2:0] = tri_dir_r;
      `KP_REG_TRI_OUT:  rdata_nxt[2:0] = tri_out_r;
      `KP_REG_TRI_RES:  rdata_nxt[2:0] = tri_res_r;
      `KP_REG_TRI_LVL:  rdata_nxt[2:0] = tri_lvl_r;
      `KP_REG_BDIR_DIR: rdata_nxt[3:0] = bdir_dir_r;
      `KP_REG_BDIR_OUT: rdata_nxt[3:0] = bdir_out_r;
      `KP_REG_GDIR_OUT: rdata_nxt[3:0] = gdir_dat_r;
      `KP_REG_CARRIER:  rdata_nxt[0]   = carrier_r;
      `KP_REG_PIN_IN:   rdata_nxt[14:0] = pin_sync_r;
      `KP_REG_IRQ_STAT: rdata_nxt[`KP_EV_W-1:0] = irq_stat_r;
      `KP_REG_IRQ_MASK: rdata_nxt[`KP_EV_W-1:0] = irq_mask_r;
      `KP_REG_STANDBY:  rdata_nxt[0]   = standby_r;
      default:          rdata_nxt = {`KP_DATA_W{1'b0}};
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= {`KP_DATA_W{1'b0}};
    end
    else if (i_rd)
    begin
      o_rdata <= rdata_nxt;
    end
    else
    begin
      o_rdata <= {`KP_DATA_W{1'b0}};
    end
  end

endmodule

// ===== testbench/key_port_checker.sv
// Concurrent checks on the port pins, wake logic and register port of the key matrix port block.
module key_port_checker
(
  // Clock, reset and register port
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  // Pins
  input wire logic [3:0]  i_key_in_port,
  input wire logic [3:0]  i_group_dir_port,
  input wire logic [2:0]  o_tri_pull_up,
  input wire logic [2:0]  o_tri_pull_dn,
  input wire logic [3:0]  o_key_in_pull_up,
  input wire logic [3:0]  o_bit_dir_port,
  input wire logic [3:0]  o_bit_dir_pull_up,
  input wire logic [3:0]  o_group_dir_port,
  input wire logic [3:0]  o_group_dir_pull_up,
  input wire logic        o_ir_carrier_out,
  input wire logic        o_standby
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ==========================================================================
  // Wake sequences: two sync flops and one register put three edges between level and release.
  sequence key_low;
    (i_key_in_port != 4'hF && !i_wr) [*4];
  endsequence
  sequence grp_low;
    (i_group_dir_port != 4'hF && o_group_dir_pull_up == 4'hF && !i_wr) [*4];
  endsequence
  // ==========================================================================
  // Assertions
  AST_KEY_WAKE: assert property (key_low |-> !o_standby) else $error("key port low left standby set");
  AST_GRP_WAKE: assert property (grp_low |-> !o_standby) else $error("group port low left standby set");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000) else $error("read data outside slot");
  // A write lands in the control register at the first edge and reaches the pin flops at the second.
  AST_CARRIER: assert property (i_wr && i_addr == 4'h8 |=> ##1 o_ir_carrier_out == $past(i_wdata[0], 2))
    else $error("carrier level wrong");
  AST_GDIR_SET: assert property (i_wr && i_addr == 4'h0 |=>
    ##1 o_group_dir_pull_up == {4{!$past(i_wdata[1], 2)}}) else $error("group direction pulls wrong");
  AST_BDIR_DIR: assert property (i_wr && i_addr == 4'h5 |=>
    ##1 o_bit_dir_pull_up == ~$past(i_wdata[3:0], 2)) else $error("bit port pulls wrong");
  AST_TRI_PULL: assert property ((o_tri_pull_up & o_tri_pull_dn) == 3'h0) else $error("both pulls on");
  AST_KEY_PULL: assert property (o_key_in_pull_up == 4'hF) else $error("key port pull missing");
  AST_OD_LOW: assert property (o_bit_dir_port == 4'h0 && o_group_dir_port == 4'h0)
    else $error("open drain drove high");
endmodule
bind key_port key_port_checker key_port_checker_inst (.*);

// ===== testbench/key_matrix_model.sv
// Behavioural model of the key matrix switches and line loads on the port pins.
module key_matrix_model
(
  // Clock and scenario controls
  input  wire logic        i_clk,
  input  wire logic [15:0] i_press,
  input  wire logic [2:0]  i_tri_hi,
  input  wire logic [2:0]  i_tri_lo,
  input  wire logic [3:0]  i_bdir_lo,
  input  wire logic [3:0]  i_grp_lo,
  // Device pin controls
  input  wire logic [2:0]  i_tri_o,
  input  wire logic [2:0]  i_tri_oe,
  input  wire logic [2:0]  i_tri_up,
  input  wire logic [2:0]  i_tri_dn,
  input  wire logic [3:0]  i_key_up,
  input  wire logic [3:0]  i_bdir_o,
  input  wire logic [3:0]  i_bdir_oe,
  input  wire logic [3:0]  i_bdir_up,
  input  wire logic [3:0]  i_grp_o,
  input  wire logic [3:0]  i_grp_oe,
  input  wire logic [3:0]  i_grp_up,
  // Resolved pin levels
  output logic      [2:0]  o_tri_pin,
  output logic      [3:0]  o_key_pin,
  output logic      [3:0]  o_bdir_pin,
  output logic      [3:0]  o_grp_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;
  // A line nobody drives or pulls wanders each cycle, so no check can lean on a settled unknown.
  always @(posedge i_clk)
    flip <= ~flip;
  always @*
  begin
    for (int b = 0; b < 4; b++)
    begin
      // A pressed key ties its return line to a strobe line that is driven low.
      o_key_pin[b] = |(i_press[b*4 +: 4] & i_grp_oe & ~i_grp_o) ? 1'b0 : (i_key_up[b] | flip);
      o_bdir_pin[b] = i_bdir_oe[b] ? i_bdir_o[b] : i_bdir_lo[b] ? 1'b0 : (i_bdir_up[b] | flip);
      o_grp_pin[b] = i_grp_oe[b] ? i_grp_o[b] : i_grp_lo[b] ? 1'b0 : (i_grp_up[b] | flip);
    end
    for (int b = 0; b < 3; b++)
      o_tri_pin[b] = i_tri_oe[b] ? i_tri_o[b] : i_tri_lo[b] ? 1'b0 : i_tri_hi[b] ? 1'b1 :
                     i_tri_up[b] ? 1'b1 : i_tri_dn[b] ? 1'b0 : flip;
  end
endmodule

// ===== testbench/key_port_tb.sv
// Self-checking bench for the key matrix port block.
module key_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0]  i_addr = 4'h0, bdir_lo = 4'h0, grp_lo = 4'h0;
  logic [15:0] i_wdata = 16'h0000, press = 16'h0000;
  logic [2:0]  tri_hi = 3'h0, tri_lo = 3'h0;
  wire  [15:0] o_rdata;
  wire  [2:0]  tri_pin, o_tri_port, o_tri_port_oe, o_tri_pull_up, o_tri_pull_dn;
  wire  [3:0]  key_pin, o_key_in_pull_up, bdir_pin, o_bit_dir_port, o_bit_dir_port_oe, o_bit_dir_pull_up;
  wire  [3:0]  grp_pin, o_group_dir_port, o_group_dir_port_oe, o_group_dir_pull_up;
  wire         o_ir_carrier_out, o_standby, o_irq;
  int          fails = 0, checked = 0;
  always #20 i_clk = ~i_clk;
  key_port key_port_inst (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_tri_port(tri_pin), .o_tri_port, .o_tri_port_oe, .o_tri_pull_up, .o_tri_pull_dn,
    .i_key_in_port(key_pin), .o_key_in_pull_up, .i_bit_dir_port(bdir_pin), .o_bit_dir_port,
    .o_bit_dir_port_oe, .o_bit_dir_pull_up, .i_group_dir_port(grp_pin), .o_group_dir_port,
    .o_group_dir_port_oe, .o_group_dir_pull_up, .o_ir_carrier_out, .o_standby, .o_irq);
  key_matrix_model key_matrix_model_inst (.i_clk, .i_press(press), .i_tri_hi(tri_hi), .i_tri_lo(tri_lo),
    .i_bdir_lo(bdir_lo), .i_grp_lo(grp_lo), .i_tri_o(o_tri_port), .i_tri_oe(o_tri_port_oe),
    .i_tri_up(o_tri_pull_up), .i_tri_dn(o_tri_pull_dn), .i_key_up(o_key_in_pull_up),
    .i_bdir_o(o_bit_dir_port), .i_bdir_oe(o_bit_dir_port_oe), .i_bdir_up(o_bit_dir_pull_up),
    .i_grp_o(o_group_dir_port), .i_grp_oe(o_group_dir_port_oe), .i_grp_up(o_group_dir_pull_up),
    .o_tri_pin(tri_pin), .o_key_pin(key_pin), .o_bdir_pin(bdir_pin), .o_grp_pin(grp_pin));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  // No wake source may be present here, or standby would drop a cycle later.
  task automatic sleep();
    wr(4'hC, 16'h0001);
    idle(2);
    chk(o_standby, 1'b1);
  endtask
  task automatic done(input int n);
    $display("test %0d finished", n);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    idle(1);
    chk({o_group_dir_port_oe, o_group_dir_port, o_key_in_pull_up}, 12'hF0F);
    chk({o_bit_dir_pull_up, o_bit_dir_port_oe, o_tri_port_oe, o_tri_pull_up, o_tri_pull_dn}, 17'h1E000);
    chk(o_ir_carrier_out, 1'b0);
    done(1);
    wr(4'hB, 16'h000F);
    sleep();
    press <= 16'h0100;
    idle(6);
    chk({o_standby, o_irq}, 2'b01);
    rd(4'hA, 16'h0002);
    chk(o_irq, 1'b0);
    press <= 16'h0000;
    done(2);
    wr(4'h0, 16'h0003);
    wr(4'h3, 16'h0007);
    wr(4'h4, 16'h0002);
    wr(4'hB, 16'h000E);
    idle(4);
    chk({o_tri_pull_up, o_tri_pull_dn}, 6'h2A);
    rd(4'h9, 16'h07FD);
    sleep();
    tri_hi <= 3'b010;
    idle(6);
    chk({o_standby, o_irq}, 2'b00);
    rd(4'hA, 16'h0001);
    wr(4'h3, 16'h0000);
    wr(4'h4, 16'h0000);
    tri_hi <= 3'b111;
    idle(4);
    chk({o_tri_pull_up, o_tri_pull_dn}, 6'h00);
    sleep();
    tri_lo <= 3'b001;
    idle(6);
    chk(o_standby, 1'b0);
    rd(4'hA, 16'h0001);
    done(3);
    wr(4'h1, 16'h0007);
    wr(4'h2, 16'h0005);
    idle(2);
    chk({o_tri_port_oe, o_tri_port}, 6'b010000);
    wr(4'h0, 16'h0002);
    idle(2);
    chk({o_tri_port_oe, o_tri_port}, 6'b111101);
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0003);
    wr(4'h4, 16'h0001);
    idle(2);
    chk({o_tri_pull_up, o_tri_pull_dn}, 6'b010001);
    done(4);
    wr(4'h5, 16'h0003);
    wr(4'h6, 16'h0001);
    idle(2);
    chk({o_bit_dir_pull_up, o_bit_dir_port_oe, o_bit_dir_port}, 12'hC20);
    sleep();
    bdir_lo <= 4'h8;
    idle(6);
    chk(o_standby, 1'b0);
    rd(4'hA, 16'h0004);
    bdir_lo <= 4'h0;
    done(5);
    wr(4'h0, 16'h0000);
    idle(2);
    chk({o_group_dir_port_oe, o_group_dir_pull_up}, 8'h0F);
    sleep();
    grp_lo <= 4'h1;
    idle(6);
    chk(o_standby, 1'b0);
    rd(4'hA, 16'h0008);
    done(6);
    wr(4'h8, 16'h0001);
    idle(2);
    chk(o_ir_carrier_out, 1'b1);
    rd(4'hF, 16'h0000);
    done(7);
    report_and_stop();
  end
  // The tests need well under 500 cycles; 2000 leaves room without hiding a hang.
  initial
  begin
    #80000;
    fails++;
    report_and_stop();
  end
endmodule
